// [pcrb_defines.svh]
// offsets, field positions and reset values of the control register bank
`ifndef PCRB_DEFINES_SVH
`define PCRB_DEFINES_SVH
`define PCRB_NUM_CR          16
`define PCRB_ADDR_W          12
`define PCRB_CR_LIMIT        12'h040
`define PCRB_STATUS_OFFSET   12'h040
`define PCRB_MASK_OFFSET     12'h044
`define PCRB_FAULT_OFFSET    12'h048
`define PCRB_CR0_RESET       32'h8080FAC0
`define PCRB_CR2_RESET_MAIN  32'hFFFFFFFF
`define PCRB_CR2_RESET_SEC   32'h00000000
`define PCRB_CR_RESET        32'h00000000
`define PCRB_TOD_SYNC_BIT    29
`define PCRB_TOD_CHECK_BIT   12
`define PCRB_RSVD_BIT        21
`define PCRB_PAGE_HI         23
`define PCRB_PAGE_LO         22
`define PCRB_SEG_HI          20
`define PCRB_SEG_LO          19
`define PCRB_ASSIST_HI       31
`define PCRB_ASSIST_LO       24
`define PCRB_PTR_HI          23
`define PCRB_PTR_LO          3
`define PCRB_EVT_HI          31
`define PCRB_EVT_LO          28
`define PCRB_GRA_HI          15
`define PCRB_GRA_LO          0
`define PCRB_MON_HI          15
`define PCRB_MON_LO          0
`define PCRB_PERA_HI         23
`define PCRB_PERA_LO         0
`define PCRB_PAGE_LEGAL      4'h6
`define PCRB_SEG_LEGAL       4'h5
`define PCRB_ST_USE_FAULT    0
`define PCRB_ST_COLLIDE      1
`define PCRB_IRQ_BITS        2
`define PCRB_RESP_OKAY       2'h0
`define PCRB_RESP_DECERR     2'h3
`endif

// [pcrb_pkg.sv]
// types and shared functions of the control register bank
package pcrb_pkg;
  `include "pcrb_defines.svh"

  typedef logic [31:0] pcrb_word_t;
  typedef logic [3:0]  pcrb_index_t;
  typedef logic [`PCRB_ADDR_W-1:0] pcrb_addr_t;

  typedef enum logic [1:0] {
    PCRB_FAULT_NONE, PCRB_FAULT_PAGE, PCRB_FAULT_SEG, PCRB_FAULT_RSVD
  } pcrb_fault_t;

  typedef enum logic [2:0] {
    PCRB_SEL_CR, PCRB_SEL_STATUS, PCRB_SEL_MASK, PCRB_SEL_FAULT, PCRB_SEL_NONE
  } pcrb_sel_t;

  // control registers live in their own space, never in storage
  function automatic pcrb_sel_t pcrb_decode(input pcrb_addr_t addr);
    if (addr[1:0] != 2'h0) return PCRB_SEL_NONE;
    if (addr < `PCRB_CR_LIMIT) return PCRB_SEL_CR;
    if (addr == `PCRB_STATUS_OFFSET) return PCRB_SEL_STATUS;
    if (addr == `PCRB_MASK_OFFSET) return PCRB_SEL_MASK;
    if (addr == `PCRB_FAULT_OFFSET) return PCRB_SEL_FAULT;
    return PCRB_SEL_NONE;
  endfunction

  function automatic pcrb_word_t pcrb_merge(input pcrb_word_t old_w, input pcrb_word_t new_w,
                                            input logic [3:0] strb);
    pcrb_word_t r;
    r = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) r[b*8 +: 8] = new_w[b*8 +: 8];
    end
    return r;
  endfunction
endpackage

// [pcrb_axil_port.sv]
// axi4-lite handshake front end of the control register bank
`timescale 1ns/1ns
`include "pcrb_defines.svh"
module pcrb_axil_port
  import pcrb_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire pcrb_addr_t  s_axil_awaddr,
  input  wire logic        s_axil_awvalid,
  output logic             s_axil_awready,
  input  wire pcrb_word_t  s_axil_wdata,
  input  wire logic [3:0]  s_axil_wstrb,
  input  wire logic        s_axil_wvalid,
  output logic             s_axil_wready,
  output logic [1:0]       s_axil_bresp,
  output logic             s_axil_bvalid,
  input  wire logic        s_axil_bready,
  input  wire pcrb_addr_t  s_axil_araddr,
  input  wire logic        s_axil_arvalid,
  output logic             s_axil_arready,
  output pcrb_word_t       s_axil_rdata,
  output logic [1:0]       s_axil_rresp,
  output logic             s_axil_rvalid,
  input  wire logic        s_axil_rready,
  output logic             wr_fire,
  output pcrb_addr_t       wr_addr,
  output pcrb_word_t       wr_data,
  output logic [3:0]       wr_strb,
  input  wire logic        wr_ok,
  output logic             rd_fire,
  output pcrb_addr_t       rd_addr,
  input  wire pcrb_word_t  rd_data,
  input  wire logic        rd_ok
);
  logic aw_held_reg;
  logic w_held_reg;
  logic bvalid_reg;
  logic rvalid_reg;
  logic [1:0] bresp_reg;
  logic [1:0] rresp_reg;
  pcrb_word_t rdata_reg;

  assign s_axil_awready = !aw_held_reg;
  assign s_axil_wready  = !w_held_reg;
  assign s_axil_arready = !rvalid_reg;
  assign s_axil_bvalid  = bvalid_reg;
  assign s_axil_bresp   = bresp_reg;
  assign s_axil_rvalid  = rvalid_reg;
  assign s_axil_rresp   = rresp_reg;
  assign s_axil_rdata   = rdata_reg;
  // write goes in once address and data are both held and no answer is pending
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  assign rd_fire = s_axil_arvalid && !rvalid_reg;
  assign rd_addr = s_axil_araddr;

  always_ff @(posedge clock) begin
    if (srst) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      rvalid_reg  <= 1'b0;
      bresp_reg   <= `PCRB_RESP_OKAY;
      rresp_reg   <= `PCRB_RESP_OKAY;
      rdata_reg   <= '0;
      wr_addr     <= '0;
      wr_data     <= '0;
      wr_strb     <= 4'h0;
    end else begin
      if (wr_fire) aw_held_reg <= 1'b0;
      if (s_axil_awvalid && !aw_held_reg) begin
        aw_held_reg <= 1'b1;
        wr_addr     <= s_axil_awaddr;
      end
      if (wr_fire) w_held_reg <= 1'b0;
      if (s_axil_wvalid && !w_held_reg) begin
        w_held_reg <= 1'b1;
        wr_data    <= s_axil_wdata;
        wr_strb    <= s_axil_wstrb;
      end
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_ok ? `PCRB_RESP_OKAY : `PCRB_RESP_DECERR;
      end else if (s_axil_bready) begin
        bvalid_reg <= 1'b0;
      end
      if (rd_fire) begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= rd_ok ? rd_data : '0;
        rresp_reg  <= rd_ok ? `PCRB_RESP_OKAY : `PCRB_RESP_DECERR;
      end else if (s_axil_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end
endmodule

// [pcrb_use_check.sv]
// point-of-use validation of translation format fields
`timescale 1ns/1ns
`include "pcrb_defines.svh"
module pcrb_use_check
  import pcrb_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        use_valid,
  input  wire pcrb_index_t use_index,
  input  wire pcrb_word_t  cr0_word,
  output logic             use_done,
  output logic             use_error,
  output pcrb_fault_t      use_fault
);
  logic [1:0]  page_code;
  logic [1:0]  seg_code;
  logic        page_bad;
  logic        seg_bad;
  logic        rsvd_bad;
  logic [3:0]  page_legal;
  logic [3:0]  seg_legal;
  pcrb_fault_t fault_now;

  // one bit per code, set where the code is legal
  assign page_legal = `PCRB_PAGE_LEGAL;
  assign seg_legal  = `PCRB_SEG_LEGAL;
  assign page_code = cr0_word[`PCRB_PAGE_HI:`PCRB_PAGE_LO];
  assign seg_code  = cr0_word[`PCRB_SEG_HI:`PCRB_SEG_LO];
  assign page_bad  = !page_legal[page_code];
  assign seg_bad   = !seg_legal[seg_code];
  assign rsvd_bad  = cr0_word[`PCRB_RSVD_BIT];
  assign fault_now = (use_index != 4'h0) ? PCRB_FAULT_NONE :
                     page_bad ? PCRB_FAULT_PAGE :
                     seg_bad  ? PCRB_FAULT_SEG :
                     rsvd_bad ? PCRB_FAULT_RSVD : PCRB_FAULT_NONE;

  always_ff @(posedge clock) begin
    if (srst) begin
      use_done  <= 1'b0;
      use_error <= 1'b0;
      use_fault <= PCRB_FAULT_NONE;
    end else begin
      use_done  <= use_valid;
      use_error <= use_valid && (fault_now != PCRB_FAULT_NONE);
      use_fault <= use_valid ? fault_now : PCRB_FAULT_NONE;
    end
  end
endmodule

// [pcrb_bank.sv]
// sixteen processor control registers with axi4-lite access and use-time checks
`timescale 1ns/1ns
`include "pcrb_defines.svh"
module pcrb_bank
  import pcrb_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        attached_secondary,
  input  wire pcrb_addr_t  s_axil_awaddr,
  input  wire logic        s_axil_awvalid,
  output logic             s_axil_awready,
  input  wire pcrb_word_t  s_axil_wdata,
  input  wire logic [3:0]  s_axil_wstrb,
  input  wire logic        s_axil_wvalid,
  output logic             s_axil_wready,
  output logic [1:0]       s_axil_bresp,
  output logic             s_axil_bvalid,
  input  wire logic        s_axil_bready,
  input  wire pcrb_addr_t  s_axil_araddr,
  input  wire logic        s_axil_arvalid,
  output logic             s_axil_arready,
  output pcrb_word_t       s_axil_rdata,
  output logic [1:0]       s_axil_rresp,
  output logic             s_axil_rvalid,
  input  wire logic        s_axil_rready,
  input  wire logic        cpu_load_valid,
  input  wire pcrb_index_t cpu_load_index,
  input  wire pcrb_word_t  cpu_load_data,
  input  wire pcrb_index_t cpu_read_index,
  output pcrb_word_t       cpu_read_data,
  input  wire logic        use_valid,
  input  wire pcrb_index_t use_index,
  output logic             use_done,
  output logic             use_error,
  output pcrb_fault_t      use_fault,
  output logic             time_of_day_clock_sync_ctrl,
  output logic             time_of_day_clock_check_mask,
  output logic [1:0]       page_size_code,
  output logic [1:0]       segment_size_code,
  output logic [7:0]       assist_enables,
  output logic [20:0]      assist_pointer,
  output pcrb_word_t       channel_masks,
  output logic [15:0]      monitor_masks,
  output logic [3:0]       program_event_recording_event_masks,
  output logic [15:0]      program_event_recording_gr_masks,
  output logic [23:0]      program_event_recording_start,
  output logic [23:0]      program_event_recording_end,
  output logic             irq
);
  pcrb_word_t cr_reg [`PCRB_NUM_CR];
  pcrb_word_t cr_next [`PCRB_NUM_CR];
  logic [`PCRB_IRQ_BITS-1:0] status_reg;
  logic [`PCRB_IRQ_BITS-1:0] status_next;
  logic [`PCRB_IRQ_BITS-1:0] mask_reg;
  logic [`PCRB_IRQ_BITS-1:0] events;
  logic [`PCRB_IRQ_BITS-1:0] w1c;
  logic [5:0]  fault_info_reg;
  logic [3:0]  use_index_reg;
  logic        strap_meta_reg;
  logic        strap_sync_reg;
  pcrb_word_t  cpu_read_data_reg;
  logic        wr_fire;
  pcrb_addr_t  wr_addr;
  pcrb_word_t  wr_data;
  logic [3:0]  wr_strb;
  logic        rd_fire;
  pcrb_addr_t  rd_addr;
  pcrb_word_t  rd_data;
  pcrb_sel_t   wr_sel;
  pcrb_sel_t   rd_sel;
  pcrb_index_t wr_index;
  pcrb_index_t rd_index;
  logic        wr_ok;
  logic        rd_ok;
  logic        bus_cr_write;
  logic        collide;

  // strap crosses in from a pin
  always_ff @(posedge clock) begin
    strap_meta_reg <= attached_secondary;
    strap_sync_reg <= strap_meta_reg;
  end

  pcrb_axil_port i_pcrb_axil_port (
    .clock          (clock),
    .srst           (srst),
    .s_axil_awaddr  (s_axil_awaddr),
    .s_axil_awvalid (s_axil_awvalid),
    .s_axil_awready (s_axil_awready),
    .s_axil_wdata   (s_axil_wdata),
    .s_axil_wstrb   (s_axil_wstrb),
    .s_axil_wvalid  (s_axil_wvalid),
    .s_axil_wready  (s_axil_wready),
    .s_axil_bresp   (s_axil_bresp),
    .s_axil_bvalid  (s_axil_bvalid),
    .s_axil_bready  (s_axil_bready),
    .s_axil_araddr  (s_axil_araddr),
    .s_axil_arvalid (s_axil_arvalid),
    .s_axil_arready (s_axil_arready),
    .s_axil_rdata   (s_axil_rdata),
    .s_axil_rresp   (s_axil_rresp),
    .s_axil_rvalid  (s_axil_rvalid),
    .s_axil_rready  (s_axil_rready),
    .wr_fire        (wr_fire),
    .wr_addr        (wr_addr),
    .wr_data        (wr_data),
    .wr_strb        (wr_strb),
    .wr_ok          (wr_ok),
    .rd_fire        (rd_fire),
    .rd_addr        (rd_addr),
    .rd_data        (rd_data),
    .rd_ok          (rd_ok)
  );

  pcrb_use_check i_pcrb_use_check (
    .clock     (clock),
    .srst      (srst),
    .use_valid (use_valid),
    .use_index (use_index),
    .cr0_word  (cr_reg[0]),
    .use_done  (use_done),
    .use_error (use_error),
    .use_fault (use_fault)
  );

  // only control, status, mask and fault words decode; the rest is refused
  assign wr_sel   = pcrb_decode(wr_addr);
  assign rd_sel   = pcrb_decode(rd_addr);
  assign wr_ok    = (wr_sel != PCRB_SEL_NONE) && (wr_sel != PCRB_SEL_FAULT);
  assign rd_ok    = (rd_sel != PCRB_SEL_NONE);
  assign wr_index = wr_addr[5:2];
  assign rd_index = rd_addr[5:2];
  assign bus_cr_write = wr_fire && (wr_sel == PCRB_SEL_CR);
  // processor load wins over a bus write to the same word
  assign collide  = bus_cr_write && cpu_load_valid && (cpu_load_index == wr_index);

  // loads store unchecked; the processor load has priority
  always_comb begin
    for (int i = 0; i < `PCRB_NUM_CR; i++) begin
      cr_next[i] = cr_reg[i];
      if (bus_cr_write && (wr_index == 4'(i)))
        cr_next[i] = pcrb_merge(cr_reg[i], wr_data, wr_strb);
      if (cpu_load_valid && (cpu_load_index == 4'(i)))
        cr_next[i] = cpu_load_data;
    end
  end

  always_ff @(posedge clock) begin
    for (int i = 0; i < `PCRB_NUM_CR; i++) begin
      if (srst) begin
        cr_reg[i] <= `PCRB_CR_RESET;
      end else begin
        cr_reg[i] <= cr_next[i];
      end
    end
    if (srst) begin
      cr_reg[0] <= `PCRB_CR0_RESET;
      cr_reg[2] <= strap_sync_reg ? `PCRB_CR2_RESET_SEC : `PCRB_CR2_RESET_MAIN;
    end
  end

  // sticky events, set wins over write-one-to-clear
  assign events[`PCRB_ST_USE_FAULT] = use_error;
  assign events[`PCRB_ST_COLLIDE]   = collide;
  assign w1c = (wr_fire && (wr_sel == PCRB_SEL_STATUS) && wr_strb[0]) ?
               wr_data[`PCRB_IRQ_BITS-1:0] : '0;
  assign status_next = (status_reg & ~w1c) | events;
  assign irq = |(status_reg & mask_reg);

  always_ff @(posedge clock) begin
    if (srst) begin
      status_reg     <= '0;
      mask_reg       <= '0;
      fault_info_reg <= '0;
      use_index_reg  <= '0;
    end else begin
      status_reg <= status_next;
      use_index_reg <= use_index;
      if (wr_fire && (wr_sel == PCRB_SEL_MASK) && wr_strb[0])
        mask_reg <= wr_data[`PCRB_IRQ_BITS-1:0];
      // index of the use that the check answered one cycle later
      if (use_error)
        fault_info_reg <= {use_index_reg, use_fault};
    end
  end

  always_ff @(posedge clock) begin
    if (srst) cpu_read_data_reg <= '0;
    else cpu_read_data_reg <= cr_reg[cpu_read_index];
  end

  assign rd_data = (rd_sel == PCRB_SEL_CR)     ? cr_reg[rd_index] :
                   (rd_sel == PCRB_SEL_STATUS) ? {30'h0, status_reg} :
                   (rd_sel == PCRB_SEL_MASK)   ? {30'h0, mask_reg} :
                   (rd_sel == PCRB_SEL_FAULT)  ? {26'h0, fault_info_reg} : 32'h0;

  // field views for the consuming logic
  assign cpu_read_data                = cpu_read_data_reg;
  assign time_of_day_clock_sync_ctrl  = cr_reg[0][`PCRB_TOD_SYNC_BIT];
  assign time_of_day_clock_check_mask = cr_reg[0][`PCRB_TOD_CHECK_BIT];
  assign page_size_code     = cr_reg[0][`PCRB_PAGE_HI:`PCRB_PAGE_LO];
  assign segment_size_code  = cr_reg[0][`PCRB_SEG_HI:`PCRB_SEG_LO];
  assign assist_enables     = cr_reg[6][`PCRB_ASSIST_HI:`PCRB_ASSIST_LO];
  assign assist_pointer     = cr_reg[6][`PCRB_PTR_HI:`PCRB_PTR_LO];
  assign channel_masks      = cr_reg[2];
  assign monitor_masks      = cr_reg[8][`PCRB_MON_HI:`PCRB_MON_LO];
  assign program_event_recording_event_masks = cr_reg[9][`PCRB_EVT_HI:`PCRB_EVT_LO];
  assign program_event_recording_gr_masks    = cr_reg[9][`PCRB_GRA_HI:`PCRB_GRA_LO];
  assign program_event_recording_start = cr_reg[10][`PCRB_PERA_HI:`PCRB_PERA_LO];
  assign program_event_recording_end   = cr_reg[11][`PCRB_PERA_HI:`PCRB_PERA_LO];

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  logic past_srst_reg;
  always_ff @(posedge clock) past_srst_reg <= srst;

  sequence s_cpu_load(int idx);
    cpu_load_valid && (cpu_load_index == 4'(idx));
  endsequence

  logic [3:0] page_legal;
  assign page_legal = `PCRB_PAGE_LEGAL;

  sequence s_bad_page_use;
    use_valid && (use_index == 4'h0) && !page_legal[page_size_code];
  endsequence

  chk_load_stores_word: assert property (
    cpu_load_valid |=> cr_reg[$past(cpu_load_index)] == $past(cpu_load_data))
    else $error("processor load not stored");

  chk_unmapped_refused: assert property (
    (s_axil_arvalid && s_axil_arready && (rd_sel == PCRB_SEL_NONE))
    |=> s_axil_rvalid && (s_axil_rresp == `PCRB_RESP_DECERR) && (s_axil_rdata == 32'h0))
    else $error("unmapped read not refused");

  chk_load_no_fault: assert property (
    (cpu_load_valid && !use_valid) |=> !use_error)
    else $error("load raised a fault");

  chk_fault_at_use: assert property (
    s_bad_page_use |=> use_error && use_done && (use_fault == PCRB_FAULT_PAGE))
    else $error("bad page code not reported at use");

  chk_fault_only_use: assert property (
    use_error |-> $past(use_valid))
    else $error("fault without a use");

  chk_tod_sync_reset: assert property (
    (past_srst_reg && !$past(cpu_load_valid)) |-> !time_of_day_clock_sync_ctrl)
    else $error("sync control not zero after reset");

  chk_tod_mask_reset: assert property (
    past_srst_reg |-> time_of_day_clock_check_mask)
    else $error("check mask not one after reset");

  chk_page_reset: assert property (
    past_srst_reg |-> (page_size_code == 2'h2) && (segment_size_code == 2'h0))
    else $error("translation codes wrong after reset");

  chk_assist_load: assert property (
    s_cpu_load(6) |=> (assist_pointer == $past(cpu_load_data[23:3]))
      && (assist_enables == $past(cpu_load_data[31:24])))
    else $error("assist fields not loaded");

  chk_event_masks: assert property (
    s_cpu_load(9) |=> (program_event_recording_gr_masks == $past(cpu_load_data[15:0]))
      && (program_event_recording_event_masks == $past(cpu_load_data[31:28])))
    else $error("recording masks not loaded");

  chk_unassigned_reset: assert property (
    past_srst_reg |-> (cr_reg[3] == 32'h0) && (cr_reg[15] == 32'h0))
    else $error("unassigned word not cleared");

  chk_channel_reset: assert property (
    past_srst_reg |-> channel_masks == (strap_sync_reg ? 32'h0 : 32'hFFFFFFFF))
    else $error("channel masks wrong after reset");

  chk_set_wins: assert property (
    (use_error && w1c[`PCRB_ST_USE_FAULT])
    |=> status_reg[`PCRB_ST_USE_FAULT] && (irq == |(status_reg & mask_reg)))
    else $error("clear beat a new event");
endmodule

// [pcrb_cpu_model.sv]
// processor side model: control register loads and point-of-use requests
`timescale 1ns/1ns
module pcrb_cpu_model
  import pcrb_pkg::*;
(
  input  wire logic  clock,
  output logic        cpu_load_valid,
  output pcrb_index_t cpu_load_index,
  output pcrb_word_t  cpu_load_data,
  output logic        use_valid,
  output pcrb_index_t use_index
);
  initial begin
    cpu_load_valid = 1'h0;
    cpu_load_index = 4'h0;
    cpu_load_data  = 32'h0;
    use_valid      = 1'h0;
    use_index      = 4'h0;
  end
  // any value goes in unchecked
  task automatic load_word(input pcrb_index_t i, input pcrb_word_t d);
    @(posedge clock);
    cpu_load_valid <= 1'h1;
    cpu_load_index <= i;
    cpu_load_data  <= d;
    @(posedge clock);
    cpu_load_valid <= 1'h0;
    cpu_load_data  <= ~d;
  endtask
  task automatic use_word(input pcrb_index_t i);
    @(posedge clock);
    use_valid <= 1'h1;
    use_index <= i;
    @(posedge clock);
    use_valid <= 1'h0;
    use_index <= ~i;
  endtask
endmodule

// [tb.sv]
// self-checking bench of the control register bank
`timescale 1ns/1ns
`include "pcrb_defines.svh"
module tb
  import pcrb_pkg::*;
;
  logic clock = 1'h0, srst = 1'h1, sec = 1'h0;
  pcrb_addr_t awaddr = 12'h0, araddr = 12'h0;
  pcrb_word_t wdata = 32'h0, rdata, cpu_rd;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, irq, done, err, sync, chk_m;
  logic [1:0] bresp, rresp, page, seg;
  pcrb_index_t rd_idx = 4'h0;
  logic [7:0] ae;
  logic [20:0] ap;
  pcrb_word_t cm;
  logic [15:0] mon, grm;
  logic [3:0] evm;
  logic [23:0] ps, pe;
  pcrb_fault_t fault;
  logic lv, uv;
  pcrb_index_t li, ui;
  pcrb_word_t ld;
  int fails = 0, total_checks = 0;
  logic [1:0] r;
  pcrb_word_t d;
  always #2 clock = ~clock;
  pcrb_cpu_model i_pcrb_cpu_model (.clock(clock), .cpu_load_valid(lv), .cpu_load_index(li),
    .cpu_load_data(ld), .use_valid(uv), .use_index(ui));
  pcrb_bank i_pcrb_bank (.clock(clock), .srst(srst), .attached_secondary(sec),
    .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid), .s_axil_awready(awready),
    .s_axil_wdata(wdata), .s_axil_wstrb(4'hF), .s_axil_wvalid(wvalid), .s_axil_wready(wready),
    .s_axil_bresp(bresp), .s_axil_bvalid(bvalid), .s_axil_bready(bready),
    .s_axil_araddr(araddr), .s_axil_arvalid(arvalid), .s_axil_arready(arready),
    .s_axil_rdata(rdata), .s_axil_rresp(rresp), .s_axil_rvalid(rvalid), .s_axil_rready(rready),
    .cpu_load_valid(lv), .cpu_load_index(li), .cpu_load_data(ld), .cpu_read_index(rd_idx),
    .cpu_read_data(cpu_rd), .use_valid(uv), .use_index(ui), .use_done(done), .use_error(err),
    .use_fault(fault), .time_of_day_clock_sync_ctrl(sync), .time_of_day_clock_check_mask(chk_m),
    .page_size_code(page), .segment_size_code(seg), .assist_enables(ae), .assist_pointer(ap),
    .channel_masks(cm), .monitor_masks(mon), .program_event_recording_event_masks(evm),
    .program_event_recording_gr_masks(grm), .program_event_recording_start(ps),
    .program_event_recording_end(pe), .irq(irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input pcrb_addr_t a, input pcrb_word_t v, output logic [1:0] resp);
    logic aw_hs, w_hs, b_hs;
    int n;
    b_hs = 1'h0;
    n = 0;
    @(posedge clock);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!b_hs && n < 200) begin
      @(negedge clock);
      aw_hs = awvalid && awready;
      w_hs = wvalid && wready;
      b_hs = bvalid && bready;
      resp = bresp;
      @(posedge clock);
      if (aw_hs) awvalid <= 1'h0;
      if (w_hs) wvalid <= 1'h0;
      n++;
    end
    bready <= 1'h0;
    if (!b_hs) fails++;
  endtask
  task automatic rd(input pcrb_addr_t a, output pcrb_word_t v, output logic [1:0] resp);
    logic ar_hs, r_hs;
    int n;
    r_hs = 1'h0;
    n = 0;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!r_hs && n < 200) begin
      @(negedge clock);
      ar_hs = arvalid && arready;
      r_hs = rvalid && rready;
      v = rdata;
      resp = rresp;
      @(posedge clock);
      if (ar_hs) arvalid <= 1'h0;
      n++;
    end
    rready <= 1'h0;
    if (!r_hs) fails++;
  endtask
  task automatic do_reset();
    @(posedge clock);
    srst <= 1'h1;
    repeat (10) @(posedge clock);
    srst <= 1'h0;
  endtask
  task automatic t_reset_values();
    rd(12'h000, d, r);
    chk(d, `PCRB_CR0_RESET, "word0 reset");
    chk({sync, chk_m, page, seg}, {1'h0, 1'h1, 2'h2, 2'h0}, "word0 fields");
    rd(12'h008, d, r);
    chk(d, 32'hFFFFFFFF, "channel masks");
    chk(cm, 32'hFFFFFFFF, "channel masks out");
    $display("test reset values done");
  endtask
  task automatic t_fields();
    wr(12'h018, 32'hA5123458, r);
    wr(12'h020, 32'h00001234, r);
    wr(12'h024, 32'hC000BEEF, r);
    wr(12'h028, 32'hFF123456, r);
    @(negedge clock);
    chk({ae, 3'h0, ap}, {8'hA5, 3'h0, 21'h2468B}, "assist fields");
    chk(mon, 32'h1234, "monitor masks");
    chk({evm, grm}, {4'hC, 16'hBEEF}, "event recording masks");
    chk(ps, 32'h123456, "start address");
    i_pcrb_cpu_model.load_word(4'hB, 32'hDEADBEEF);
    rd_idx <= 4'hB;
    @(posedge clock);
    @(negedge clock);
    chk(pe, 32'hADBEEF, "end address");
    chk(cpu_rd, 32'hDEADBEEF, "processor read");
    fork
      wr(12'h00C, 32'h11111111, r);
      begin
        @(posedge clock);
        i_pcrb_cpu_model.load_word(4'h3, 32'h22222222);
      end
    join
    rd(12'h00C, d, r);
    chk(d, 32'h22222222, "processor load wins");
    rd(12'h040, d, r);
    chk(d[1], 1'h1, "collision status");
    $display("test fields done");
  endtask
  task automatic t_use_faults();
    pcrb_word_t val [4] = '{32'h00000000, 32'h00880000, 32'h00A00000, 32'h00800000};
    pcrb_fault_t ef [4] = '{PCRB_FAULT_PAGE, PCRB_FAULT_SEG, PCRB_FAULT_RSVD, PCRB_FAULT_NONE};
    for (int k = 0; k < 4; k++) begin
      wr(12'h000, val[k], r);
      chk(r, `PCRB_RESP_OKAY, "load of bad code accepted");
      i_pcrb_cpu_model.use_word(4'h0);
      @(negedge clock);
      chk({done, err, fault}, {1'h1, ef[k] != PCRB_FAULT_NONE, ef[k]}, "use check");
    end
    i_pcrb_cpu_model.use_word(4'h2);
    @(negedge clock);
    chk({done, err}, 2'h2, "other word never faults");
    rd(12'h048, d, r);
    chk(d, 32'h3, "fault info");
    rd(12'h040, d, r);
    chk(d[0], 1'h1, "use fault status");
    chk(irq, 1'h0, "masked interrupt");
    wr(12'h044, 32'h1, r);
    @(negedge clock);
    chk(irq, 1'h1, "unmasked interrupt");
    wr(12'h040, 32'h1, r);
    @(negedge clock);
    chk(irq, 1'h0, "cleared interrupt");
    wr(12'h000, 32'h0, r);
    fork
      wr(12'h040, 32'h1, r);
      i_pcrb_cpu_model.use_word(4'h0);
    join
    rd(12'h040, d, r);
    chk(d[0], 1'h1, "set wins over clear");
    chk(irq, 1'h1, "interrupt after set wins");
    $display("test use faults done");
  endtask
  task automatic t_decode();
    rd(12'h100, d, r);
    chk({r, d}, {`PCRB_RESP_DECERR, 32'h0}, "unmapped read");
    rd(12'h002, d, r);
    chk(r, `PCRB_RESP_DECERR, "unaligned read");
    wr(12'h048, 32'h1, r);
    chk(r, `PCRB_RESP_DECERR, "read-only write");
    $display("test decode done");
  endtask
  task automatic t_secondary();
    sec <= 1'h1;
    do_reset();
    rd(12'h008, d, r);
    chk(d, 32'h0, "secondary channel masks");
    chk(cm, 32'h0, "secondary channel masks out");
    $display("test secondary done");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #(4 * 20000);
    fails++;
    results();
  end
  initial begin
    do_reset();
    t_reset_values();
    t_fields();
    t_use_faults();
    t_decode();
    t_secondary();
    results();
  end
endmodule
